// ==== bit_error_injector.sv ====
// Bit error injector on a 32-lane pattern word stream
`timescale 1ns/1ps
module bit_error_injector
    import err_inj_pkg::*;
(
    input  logic                  ref_clk_i,
    input  logic                  rst_i,
    input  logic                  enable_i,
    input  source_e               source_i,
    input  variation_e            variation_i,
    input  route_e                route_i,
    input  logic                  aux_is_inject_i,
    input  logic                  aux_i,
    input  logic                  single_req_i,
    input  logic [LANE_NUM_W-1:0] lane_num_i,
    input  logic [RATE_W-1:0]     rate_mantissa_i,
    input  logic [RATE_W-1:0]     rate_exponent_i,
    input  logic                  combined_i,
    input  pattern_e              pattern_i,
    input  alt_sel_e              alt_sel_i,
    input  logic [AREA_W-1:0]     area_mask_i,
    input  logic [AREA_W-1:0]     area_mask_a_i,
    input  logic [AREA_W-1:0]     area_mask_b_i,
    input  logic [AREA_W-1:0]     area_mask_ab_i,
    input  logic [BLOCK_W-1:0]    seq_block_i,
    input  logic                  in_valid_i,
    output logic                  in_ready_o,
    input  logic [LANES-1:0]      in_data_i,
    input  logic                  word_area_i,
    input  logic                  word_pat_b_i,
    input  logic [BLOCK_W-1:0]    word_block_i,
    output logic                  out_valid_o,
    input  logic                  out_ready_i,
    output logic [LANES-1:0]      out_data_o,
    output logic                  source_refused_o,
    output logic                  inserted_o,
    output logic [LANE_W-1:0]     lane_o
);
    logic [ACC_W-1:0]  acc;
    logic [ACC_W-1:0]  next_acc;
    logic [ACC_W-1:0]  acc_sum;
    logic [ACC_W-1:0]  p10;
    logic [LANE_W-1:0] scan_lane;
    logic [LANE_W-1:0] next_scan_lane;
    logic [LANE_W-1:0] sel_lane;
    logic [LANE_W-1:0] lane_idx;
    logic [LANE_W-1:0] next_lane_o;
    logic [LANE_NUM_W-1:0] lane_num_eff;
    logic [RATE_W-1:0] mant_eff;
    logic [RATE_W-1:0] exp_eff;
    logic [RATE_W-1:0] exp_floor;
    logic              aux_q;
    logic              pending;
    logic              next_pending;
    logic              single_pend;
    logic              next_single_pend;
    logic              next_inserted;
    logic              accept;
    logic              ext_src;
    logic              src_ok;
    logic              rate_active;
    logic              tick_int;
    logic              trig_edge;
    logic              rep_event;
    logic              req;
    logic              new_single;
    logic              gate_ok;
    logic              eligible;
    logic              ins;
    logic              ins_single;
    logic [LANES-1:0]  flip_mask;

    assign accept  = in_valid_i && in_ready_o;
    assign ext_src = (source_i == SRC_EXT_TRIGGER) || (source_i == SRC_EXT_GATE);
    assign src_ok  = !ext_src || aux_is_inject_i;
    assign source_refused_o = !src_ok;

    // Rate setting clamp; the ports hold it while disabled
    always_comb begin
        exp_floor = combined_i ? EXP_MIN_COMB : EXP_MIN;
        exp_eff   = rate_exponent_i;
        if (exp_eff < exp_floor) begin
            exp_eff = exp_floor;
        end
        if (exp_eff > EXP_MAX) begin
            exp_eff = EXP_MAX;
        end
        mant_eff = rate_mantissa_i;
        if (mant_eff < MANT_MIN) begin
            mant_eff = MANT_MIN;
        end
        if (mant_eff > MANT_MAX) begin
            mant_eff = MANT_MAX;
        end
        if (exp_eff == EXP_MIN) begin
            mant_eff = MANT_MIN;
        end
    end

    // Accumulate 32*x per word against 10^n; at most one hit per word since 32*x < 10^n
    assign p10         = pow10(exp_eff);
    assign acc_sum     = acc + ACC_W'({mant_eff, 5'h00});
    assign rate_active = enable_i && (variation_i == VAR_REPEAT)
                         && (source_i != SRC_EXT_TRIGGER);
    assign tick_int    = rate_active && accept && (acc_sum >= p10);

    always_comb begin
        next_acc = acc;
        if (!rate_active) begin
            next_acc = ACC_RST;
        end else if (accept) begin
            next_acc = (acc_sum >= p10) ? (acc_sum - p10) : acc_sum;
        end
    end

    assign trig_edge = aux_i && !aux_q;
    assign gate_ok   = (source_i != SRC_EXT_GATE) || aux_i;

    always_comb begin
        rep_event = 1'b0;
        // Trigger edges insert whatever the variation; internal ticks already need repeat
        if (enable_i && src_ok) begin
            case (source_i)
                SRC_INTERNAL:    rep_event = tick_int;
                SRC_EXT_GATE:    rep_event = tick_int && aux_i;
                SRC_EXT_TRIGGER: rep_event = trig_edge;
                default:         rep_event = 1'b0;
            endcase
        end
    end

    assign new_single = enable_i && src_ok && single_req_i && (variation_i == VAR_SINGLE)
                        && (source_i != SRC_EXT_TRIGGER);
    assign req = pending || rep_event;

    // Area and block qualification of the current word
    always_comb begin
        case (pattern_i)
            PAT_MIXED: begin
                eligible = area_mask_i[word_area_i];
            end
            PAT_MIXED_ALT: begin
                case (alt_sel_i)
                    ALT_ONLY_A: eligible = !word_pat_b_i && area_mask_a_i[word_area_i];
                    ALT_ONLY_B: eligible = word_pat_b_i && area_mask_b_i[word_area_i];
                    default:    eligible = area_mask_ab_i[word_area_i];
                endcase
            end
            PAT_ALTERNATE: begin
                case (alt_sel_i)
                    ALT_ONLY_A: eligible = !word_pat_b_i;
                    ALT_ONLY_B: eligible = word_pat_b_i;
                    default:    eligible = 1'b1;
                endcase
            end
            PAT_SEQUENCE: begin
                eligible = (word_block_i == seq_block_i);
            end
            default: begin
                eligible = 1'b1;
            end
        endcase
    end

    assign ins        = enable_i && src_ok && accept && eligible && gate_ok
                        && (req || single_pend);
    assign ins_single = ins && !req && single_pend;

    // A new request in the cycle of consumption stays pending
    always_comb begin
        next_pending     = enable_i && src_ok && (ins ? (pending && rep_event) : req);
        next_single_pend = enable_i && src_ok && (source_i != SRC_EXT_TRIGGER)
                           && (variation_i == VAR_SINGLE)
                           && (new_single || (single_pend && !ins_single));
    end

    // Lane choice; out-of-range lane numbers saturate
    always_comb begin
        lane_num_eff = lane_num_i;
        if (lane_num_eff < LANE_MIN) begin
            lane_num_eff = LANE_MIN;
        end
        if (lane_num_eff > LANE_MAX) begin
            lane_num_eff = LANE_MAX;
        end
        sel_lane       = LANE_W'(lane_num_eff - LANE_MIN);
        lane_idx       = (route_i == ROUTE_SCAN) ? scan_lane : sel_lane;
        next_scan_lane = ins ? (scan_lane + 5'h01) : scan_lane;
        next_lane_o    = ins ? lane_idx : lane_o;
        next_inserted  = ins;
    end

    genvar gi;
    generate
        for (gi = 0; gi < LANES; gi++) begin : g_flip
            assign flip_mask[gi] = ins && (lane_idx == LANE_W'(gi));
        end
    endgenerate

    pair_buffer #(
        .W(LANES)
    ) u_buf (
        .ref_clk_i  (ref_clk_i),
        .rst_i      (rst_i),
        .in_valid_i (in_valid_i),
        .in_ready_o (in_ready_o),
        .in_data_i  (in_data_i ^ flip_mask),
        .out_valid_o(out_valid_o),
        .out_ready_i(out_ready_i),
        .out_data_o (out_data_o)
    );

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            acc         <= ACC_RST;
            aux_q       <= 1'b0;
            pending     <= 1'b0;
            single_pend <= 1'b0;
            scan_lane   <= SCAN_RST;
            lane_o      <= SCAN_RST;
            inserted_o  <= 1'b0;
        end else begin
            acc         <= next_acc;
            aux_q       <= aux_i;
            pending     <= next_pending;
            single_pend <= next_single_pend;
            scan_lane   <= next_scan_lane;
            lane_o      <= next_lane_o;
            inserted_o  <= next_inserted;
        end
    end

    AST_ENABLE_GATES: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !enable_i |=> !inserted_o && !pending && !single_pend)
        else $error("Insertion while disabled");

    AST_AUX_REFUSED: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (ext_src && !aux_is_inject_i) |=> !inserted_o)
        else $error("External source used without aux configured");

    AST_GATE_LOW: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (source_i == SRC_EXT_GATE && !aux_i) |=> !inserted_o)
        else $error("Insertion while gate input low");

    AST_TRIG_NO_SINGLE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (source_i == SRC_EXT_TRIGGER) |=> !single_pend)
        else $error("Single request held in trigger mode");

    AST_SINGLE_ONCE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (ins_single && !new_single) |=> !single_pend ##1 !inserted_o || rep_event)
        else $error("Single request produced more than one error");

    AST_SCAN_STEP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (ins && route_i == ROUTE_SCAN) |=> scan_lane == $past(scan_lane) + 5'h01)
        else $error("Scan lane did not advance");

    AST_SELECT_LANE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (ins && route_i == ROUTE_SELECT) |=> lane_o == LANE_W'($past(lane_num_eff) - LANE_MIN))
        else $error("Error placed off the selected lane");

    AST_ONE_BIT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ins |-> $onehot(flip_mask))
        else $error("Inserted error does not flip exactly one bit");

    AST_RATE_RANGE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        exp_eff >= (combined_i ? EXP_MIN_COMB : EXP_MIN) && exp_eff <= EXP_MAX
        && (exp_eff != EXP_MIN || mant_eff == MANT_MIN))
        else $error("Effective rate setting out of range");

    AST_SEQ_BLOCK: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (ins && pattern_i == PAT_SEQUENCE) |-> word_block_i == seq_block_i)
        else $error("Sequence insertion outside chosen block");

    AST_TRIG_EDGE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (enable_i && src_ok && source_i == SRC_EXT_TRIGGER && trig_edge) |=> pending || inserted_o)
        else $error("Trigger edge lost");

    AST_HIT_ONCE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (ins && rep_event && !pending) |=> !pending)
        else $error("Consumed hit left a request pending");

    AST_REPEAT_HIT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (tick_int && src_ok && source_i == SRC_INTERNAL && eligible) |=> inserted_o)
        else $error("Internal hit on an eligible word not inserted");

    AST_SINGLE_SET: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        new_single |=> single_pend)
        else $error("Single request not held");

    AST_RATE_IDLE: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !rate_active |=> acc == ACC_RST)
        else $error("Rate accumulator ran while rate unused");

    AST_GATE_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (enable_i && src_ok && source_i == SRC_EXT_GATE && !aux_i && pending) |=> pending)
        else $error("Pending request dropped while gate low");

    AST_LANE_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !ins |=> lane_o == $past(lane_o))
        else $error("Lane changed without an insertion");

    AST_SCAN_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !ins |=> scan_lane == $past(scan_lane))
        else $error("Scan lane moved without an insertion");
endmodule

// ==== err_inj_pkg.sv ====
// Constants, types and rate table for the bit error injector
// Operation
// - Internal source: repeat insertion instants come only from the rate generator.
// - External trigger: one error per rising edge on the auxiliary input.
// - External gate: internal timing, no insertion while auxiliary input low.
// - External sources refused unless auxiliary input configured for injection.
// - Repeat: insert at every generated instant while enabled.
// - Single: exactly one error per one-shot request.
// - Single only with internal or gate source, never with trigger source.
// - Scan: move to the next of 32 lanes after each inserted error.
// - Select: every error goes on the lane chosen by the lane number.
// - Lane number accepts 1 through 32.
// - Lane number kept while disabled, ignored in scan routing.
// - Rate is x times ten to minus n, x 1..9, n 2..12.
// - Combined channels limit exponent n to 3..12.
// - Exponent 2 forces mantissa to 1.
// - Rate kept while disabled, ignored in single and trigger modes.
// - Mixed: one area mask applied to every block.
// - Mixed alternate: separate area masks for A, B and both.
// - Alternate: insert on only A, only B, or both.
// - Sequence: insert only in one chosen block.
// - Master enable gates every path, external trigger included.
package err_inj_pkg;
    localparam int LANES        = 32;
    localparam int LANE_W       = 5;
    localparam int LANE_NUM_W   = 6;
    localparam int RATE_W       = 4;
    localparam int ACC_W        = 41;
    localparam int BLOCK_W      = 8;
    localparam int AREA_W       = 2;
    localparam logic [LANE_NUM_W-1:0] LANE_MIN = 6'h01;
    localparam logic [LANE_NUM_W-1:0] LANE_MAX = 6'h20;
    localparam logic [RATE_W-1:0] MANT_MIN     = 4'h1;
    localparam logic [RATE_W-1:0] MANT_MAX     = 4'h9;
    localparam logic [RATE_W-1:0] EXP_MIN      = 4'h2;
    localparam logic [RATE_W-1:0] EXP_MIN_COMB = 4'h3;
    localparam logic [RATE_W-1:0] EXP_MAX      = 4'hc;
    localparam logic [LANE_W-1:0] SCAN_RST     = 5'h00;
    localparam logic [ACC_W-1:0]  ACC_RST      = 41'h0;

    typedef enum logic [1:0] {SRC_INTERNAL, SRC_EXT_TRIGGER, SRC_EXT_GATE} source_e;
    typedef enum logic {VAR_REPEAT, VAR_SINGLE} variation_e;
    typedef enum logic {ROUTE_SCAN, ROUTE_SELECT} route_e;
    typedef enum logic [2:0] {PAT_PLAIN, PAT_MIXED, PAT_MIXED_ALT, PAT_ALTERNATE,
                              PAT_SEQUENCE} pattern_e;
    typedef enum logic [1:0] {ALT_ONLY_A, ALT_ONLY_B, ALT_BOTH} alt_sel_e;

    function automatic logic [ACC_W-1:0] pow10(input logic [RATE_W-1:0] n);
        case (n)
            4'h2:    pow10 = 41'h64;
            4'h3:    pow10 = 41'h3e8;
            4'h4:    pow10 = 41'h2710;
            4'h5:    pow10 = 41'h186a0;
            4'h6:    pow10 = 41'hf4240;
            4'h7:    pow10 = 41'h989680;
            4'h8:    pow10 = 41'h5f5e100;
            4'h9:    pow10 = 41'h3b9aca00;
            4'ha:    pow10 = 41'h2540be400;
            4'hb:    pow10 = 41'h174876e800;
            default: pow10 = 41'he8d4a51000;
        endcase
    endfunction
endpackage

// ==== pair_buffer.sv ====
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module pair_buffer #(
    parameter int W = 32
) (
    input  logic         ref_clk_i,
    input  logic         rst_i,
    input  logic         in_valid_i,
    output logic         in_ready_o,
    input  logic [W-1:0] in_data_i,
    output logic         out_valid_o,
    input  logic         out_ready_i,
    output logic [W-1:0] out_data_o
);
    logic [W-1:0] mem [2];
    logic [W-1:0] next_mem [2];
    logic         wr_ptr;
    logic         rd_ptr;
    logic [1:0]   count;
    logic         next_wr_ptr;
    logic         next_rd_ptr;
    logic [1:0]   next_count;
    logic         push;
    logic         pop;

    assign in_ready_o  = (count != 2'h2);
    assign out_valid_o = (count != 2'h0);
    assign out_data_o  = mem[rd_ptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        next_mem    = mem;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (push) begin
            next_mem[wr_ptr] = in_data_i;
            next_wr_ptr      = !wr_ptr;
        end
        if (pop) begin
            next_rd_ptr = !rd_ptr;
        end
        case ({push, pop})
            2'b10:   next_count = count + 2'h1;
            2'b01:   next_count = count - 2'h1;
            default: next_count = count;
        endcase
    end

    // Storage needs no reset; count alone decides what is valid
    always_ff @(posedge ref_clk_i) begin
        mem <= next_mem;
        if (rst_i) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end
endmodule

// ==== err_sink.sv ====
// Far-side word sink that stalls on command and tallies words with flipped bits
`timescale 1ns/1ps
module err_sink
    import err_inj_pkg::*;
(
    input  logic             ref_clk_i,
    input  logic             rst_i,
    input  logic             stall_i,
    input  logic [LANES-1:0] base_i,
    input  logic             out_valid_i,
    input  logic [LANES-1:0] out_data_i,
    output logic             out_ready_o,
    output int               words_o,
    output int               errs_o,
    output int               multi_o,
    output logic [LANES-1:0] last_err_o
);
    logic [LANES-1:0] diff;

    // Ready held low while stalled, so the buffer must keep every word
    assign out_ready_o = !stall_i;
    assign diff        = out_data_i ^ base_i;

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            words_o    <= 0;
            errs_o     <= 0;
            multi_o    <= 0;
            last_err_o <= '0;
        end else if (out_valid_i && out_ready_o) begin
            words_o <= words_o + 1;
            if (diff !== '0) begin
                errs_o     <= errs_o + 1;
                last_err_o <= diff;
            end
            // More than one flipped bit in a word, or unknowns, is a fault
            if (diff !== '0 && $countones(diff) !== 1) begin
                multi_o <= multi_o + 1;
            end
        end
    end
endmodule

// ==== bit_error_injector_tb_top.sv ====
// Self-checking bench for the bit error injector
`timescale 1ns/1ps
`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; \
    $display("wrong value %s exp %0h got %0h", what, (exp), (got)); end end
module bit_error_injector_tb_top
    import err_inj_pkg::*;
;
    logic                  ref_clk_i, rst_i, enable_i, aux_is_inject_i, aux_i;
    logic                  single_req_i, combined_i, in_valid_i, word_area_i, word_pat_b_i;
    logic                  out_ready_i, in_ready_o, out_valid_o, source_refused_o, inserted_o;
    source_e               source_i;
    variation_e            variation_i;
    route_e                route_i;
    pattern_e              pattern_i;
    alt_sel_e              alt_sel_i;
    logic [LANE_NUM_W-1:0] lane_num_i;
    logic [RATE_W-1:0]     rate_mantissa_i, rate_exponent_i;
    logic [AREA_W-1:0]     area_mask_i, area_mask_a_i, area_mask_b_i, area_mask_ab_i;
    logic [BLOCK_W-1:0]    seq_block_i, word_block_i;
    logic [LANES-1:0]      in_data_i, out_data_o, last_err;
    logic [LANE_W-1:0]     lane_o;
    logic                  stall;
    int                    errs, words, multi, ins_cnt, error_cnt, samples_checked;
    logic [LANE_NUM_W-1:0] ln[4] = '{6'h05, 6'h00, 6'h28, 6'h20};
    logic [LANE_W-1:0]     lx[4] = '{5'h04, 5'h00, 5'h1f, 5'h1f};
    logic [RATE_W-1:0]     rx[4] = '{4'h1, 4'h9, 4'h1, 4'h5};
    logic [RATE_W-1:0]     rn[4] = '{4'h2, 4'h2, 4'h2, 4'h3};
    logic                  rc[4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    int                    re[4] = '{32, 32, 3, 16};
    pattern_e              pt[4] = '{PAT_SEQUENCE, PAT_ALTERNATE, PAT_MIXED, PAT_MIXED_ALT};
    alt_sel_e              al[4] = '{ALT_BOTH, ALT_ONLY_B, ALT_BOTH, ALT_ONLY_A};
    logic [9:0]            bad[4] = '{10'h002, 10'h000, 10'h000, 10'h200};
    logic [9:0]            good[4] = '{10'h003, 10'h100, 10'h200, 10'h000};

    bit_error_injector dut (.ref_clk_i, .rst_i, .enable_i, .source_i, .variation_i, .route_i,
        .aux_is_inject_i, .aux_i, .single_req_i, .lane_num_i, .rate_mantissa_i,
        .rate_exponent_i, .combined_i, .pattern_i, .alt_sel_i, .area_mask_i, .area_mask_a_i,
        .area_mask_b_i, .area_mask_ab_i, .seq_block_i, .in_valid_i, .in_ready_o, .in_data_i,
        .word_area_i, .word_pat_b_i, .word_block_i, .out_valid_o, .out_ready_i, .out_data_o,
        .source_refused_o, .inserted_o, .lane_o);

    err_sink sink (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .stall_i(stall), .base_i(in_data_i),
        .out_valid_i(out_valid_o), .out_data_i(out_data_o), .out_ready_o(out_ready_i),
        .words_o(words), .errs_o(errs), .multi_o(multi), .last_err_o(last_err));

    always #2.5 ref_clk_i = !ref_clk_i;

    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            ins_cnt <= 0;
        end else if (inserted_o === 1'b1) begin
            ins_cnt <= ins_cnt + 1;
        end
    end

    task automatic tick();
        @(posedge ref_clk_i);
        #1;
    endtask

    task automatic do_reset();
        rst_i = 1'b1;
        repeat (8) tick();
        rst_i = 1'b0;
    endtask

    // Word held until a ready edge takes it
    task automatic send(input int n, input logic [9:0] sb);
        int k;
        int g;
        {word_area_i, word_pat_b_i, word_block_i} = sb;
        in_valid_i = 1'b1;
        for (k = 0; k < n; k++) begin
            g = 0;
            while (in_ready_o !== 1'b1 && g < 200) begin
                tick();
                g++;
            end
            if (g >= 200) begin
                error_cnt++;
            end
            tick();
        end
        in_valid_i = 1'b0;
        repeat (4) tick();
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        tick();
        s = 1'b0;
        tick();
    endtask

    task automatic chk_errs(input int exp);
        `CHK("errors", exp, errs)
        `CHK("pulses", exp, ins_cnt)
        `CHK("multi bit words", 0, multi)
    endtask

    task automatic end_sim();
        $display("compares %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        // Cycle budget for all scenarios is well below this span
        #200000;
        error_cnt++;
        end_sim();
    end

    initial begin
        int i;
        {ref_clk_i, rst_i, aux_is_inject_i, aux_i, single_req_i, combined_i} = '0;
        {in_valid_i, word_area_i, word_pat_b_i, stall} = '0;
        enable_i = 1'b1;
        source_i = SRC_INTERNAL;
        variation_i = VAR_SINGLE;
        route_i = ROUTE_SELECT;
        pattern_i = PAT_PLAIN;
        alt_sel_i = ALT_BOTH;
        lane_num_i = 6'h01;
        {rate_mantissa_i, rate_exponent_i} = {4'h1, 4'h2};
        {area_mask_i, area_mask_a_i, area_mask_b_i, area_mask_ab_i} = 8'h97;
        {seq_block_i, word_block_i} = {8'h03, 8'h00};
        in_data_i = 32'h0;
        error_cnt = 0;
        samples_checked = 0;
        do_reset();
        `CHK("ready after reset", 1'b1, in_ready_o)
        `CHK("valid after reset", 1'b0, out_valid_o)
        `CHK("lane after reset", 5'h00, lane_o)
        for (i = 0; i < 4; i++) begin
            lane_num_i = ln[i];
            pulse(single_req_i);
            send(3, 10'h000);
            chk_errs(i + 1);
            `CHK("select lane", lx[i], lane_o)
            `CHK("select mask", 32'h1 << lx[i], last_err)
        end
        do_reset();
        route_i = ROUTE_SCAN;
        for (i = 0; i < 3; i++) begin
            pulse(single_req_i);
            send(2, 10'h000);
            `CHK("scan mask", 32'h1 << i, last_err)
        end
        variation_i = VAR_REPEAT;
        for (i = 0; i < 4; i++) begin
            do_reset();
            {rate_mantissa_i, rate_exponent_i, combined_i} = {rx[i], rn[i], rc[i]};
            send(100, 10'h000);
            chk_errs(re[i]);
        end
        do_reset();
        {rate_mantissa_i, rate_exponent_i, combined_i} = {4'h1, 4'h2, 1'b0};
        {source_i, aux_is_inject_i} = {SRC_EXT_GATE, 1'b1};
        send(100, 10'h000);
        chk_errs(0);
        aux_i = 1'b1;
        send(100, 10'h000);
        chk_errs(32);
        aux_i = 1'b0;
        do_reset();
        {source_i, variation_i} = {SRC_EXT_TRIGGER, VAR_SINGLE};
        for (i = 0; i < 3; i++) begin
            pulse(aux_i);
            pulse(single_req_i);
            send(2, 10'h000);
        end
        chk_errs(3);
        enable_i = 1'b0;
        pulse(aux_i);
        send(2, 10'h000);
        enable_i = 1'b1;
        send(2, 10'h000);
        chk_errs(3);
        aux_is_inject_i = 1'b0;
        tick();
        `CHK("refused", 1'b1, source_refused_o)
        pulse(aux_i);
        send(2, 10'h000);
        chk_errs(3);
        do_reset();
        {source_i, aux_is_inject_i} = {SRC_INTERNAL, 1'b0};
        for (i = 0; i < 4; i++) begin
            {pattern_i, alt_sel_i} = {pt[i], al[i]};
            pulse(single_req_i);
            send(4, bad[i]);
            chk_errs(i);
            send(1, good[i]);
            chk_errs(i + 1);
        end
        do_reset();
        in_data_i = 32'ha5a55a5a;
        stall = 1'b1;
        fork
            send(3, 10'h000);
            begin
                repeat (6) tick();
                `CHK("ready when full", 1'b0, in_ready_o)
                stall = 1'b0;
            end
        join
        `CHK("words drained", 3, words)
        `CHK("valid when empty", 1'b0, out_valid_o)
        chk_errs(0);
        end_sim();
    end
endmodule
